// file: lin_timeout_compare_mode_switch.sv
`default_nettype none
module lin_timeout_compare_mode_switch
   import lin_to_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        NRST,
   // axi4-lite write channels
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   // axi4-lite read channels
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // serial pins and frame marker
   input  wire logic        RXD,
   input  wire logic        TXD_MON,
   input  wire logic        FRAME,
   // events
   output logic             TIMEOUT,
   output logic             IRQ
);
   // ==========================================================
   // reset release and pin synchronisers
   logic       rst_m_q, rst_n_q;
   logic [2:0] pin_s1_q, pin_s2_q;
   logic [1:0] pin_old_q;

   // async assert, clocked release
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   // two flops before any logic sees a pin
   always_ff @(posedge CLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         // idle line: pins high, no frame, so no false edge after reset
         pin_s1_q  <= 3'h3;
         pin_s2_q  <= 3'h3;
         pin_old_q <= 2'h3;
      end
      else
      begin
         pin_s1_q  <= {FRAME, TXD_MON, RXD};
         pin_s2_q  <= pin_s1_q;
         pin_old_q <= pin_s2_q[1:0];
      end
   end

   logic pin_act;
   logic frame_s;
   assign pin_act = |(pin_s2_q[1:0] ^ pin_old_q);
   assign frame_s = pin_s2_q[2];

   // ==========================================================
   // axi4-lite slave
   logic        aw_have_q, w_have_q;
   wr_req_t     wr_q;
   logic        wr_fire;
   logic        mode_q;
   cmp_t        ocr_q;
   logic [1:0]  ucr_q;
   logic [7:0]  cnt_q;
   logic        irqs_q, irqm_q;

   function automatic logic known(input logic [7:0] a);
      known = (a == TCSR_OFS) || (a == OCR_OFS) || (a == UCR_OFS) ||
              (a == CNT_OFS) || (a == IRQS_OFS) || (a == IRQM_OFS);
   endfunction : known

   assign wr_fire = aw_have_q && w_have_q && !BVALID;

   // address and data taken in either order, response after both
   always_ff @(posedge CLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         wr_q      <= '0;
         AWREADY   <= 1'b0;
         WREADY    <= 1'b0;
         BVALID    <= 1'b0;
         BRESP     <= RESP_OKAY;
      end
      else
      begin
         AWREADY <= !aw_have_q && !(AWVALID && AWREADY);
         WREADY  <= !w_have_q && !(WVALID && WREADY);
         if (AWVALID && AWREADY)
         begin
            aw_have_q  <= 1'b1;
            wr_q.addr  <= AWADDR;
         end
         if (WVALID && WREADY)
         begin
            w_have_q  <= 1'b1;
            wr_q.data <= WDATA;
            wr_q.strb <= WSTRB;
         end
         if (wr_fire)
         begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            BVALID    <= 1'b1;
            BRESP     <= known(wr_q.addr) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (BVALID && BREADY)
            BVALID <= 1'b0;
      end
   end

   // read path, one cycle after the address is taken
   always_ff @(posedge CLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0;
         RRESP   <= RESP_OKAY;
      end
      else
      begin
         ARREADY <= !RVALID && !(ARVALID && ARREADY);
         if (ARVALID && ARREADY)
         begin
            RVALID <= 1'b1;
            RRESP  <= known(ARADDR) ? RESP_OKAY : RESP_SLVERR;
            case (ARADDR)
               TCSR_OFS: RDATA <= {31'h0, mode_q};
               OCR_OFS:  RDATA <= {16'h0, ocr_q};
               UCR_OFS:  RDATA <= {30'h0, ucr_q};
               CNT_OFS:  RDATA <= {24'h0, cnt_q};
               IRQS_OFS: RDATA <= {31'h0, irqs_q};
               IRQM_OFS: RDATA <= {31'h0, irqm_q};
               default:  RDATA <= 32'h0;
            endcase
         end
         else if (RVALID && RREADY)
            RVALID <= 1'b0;
      end
   end

   // ==========================================================
   // control registers and compare values
   logic w_tcsr, w_ocr, w_ucr, w_irqs, w_irqm;
   logic lin_mode;
   assign w_tcsr   = wr_fire && wr_q.addr == TCSR_OFS && wr_q.strb[0];
   assign w_ocr    = wr_fire && wr_q.addr == OCR_OFS;
   assign w_ucr    = wr_fire && wr_q.addr == UCR_OFS && wr_q.strb[0];
   assign w_irqs   = wr_fire && wr_q.addr == IRQS_OFS && wr_q.strb[0];
   assign w_irqm   = wr_fire && wr_q.addr == IRQM_OFS && wr_q.strb[0];
   assign lin_mode = ucr_q[UCR_EN_BIT] && ucr_q[UCR_UART_BIT];

   // mode bit, uart control and interrupt mask
   always_ff @(posedge CLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         mode_q <= MODE_RST;
         ucr_q  <= UCR_RST;
         irqm_q <= 1'b0;
      end
      else
      begin
         if (w_tcsr)
            mode_q <= wr_q.data[TCSR_MODE_BIT];
         if (w_ucr)
            ucr_q <= wr_q.data[1:0];
         if (w_irqm)
            irqm_q <= wr_q.data[IRQ_TO_BIT];
      end
   end

   // the flaw is kept: uart traffic with mode at zero scribbles cv2, a mode fall keeps stale values
   always_ff @(posedge CLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
         ocr_q <= OCR_RST;
      else if (w_ocr)
      begin
         if (wr_q.strb[0])
            ocr_q.cv1 <= wr_q.data[7:0];
         if (wr_q.strb[1])
            ocr_q.cv2 <= wr_q.data[15:8];
      end
      else if (ucr_q[UCR_EN_BIT] && !ucr_q[UCR_UART_BIT] && !mode_q && pin_act)
         ocr_q.cv2 <= cnt_q;
      // mode 1 to 0 in lin: no reload, old pair stays
   end

   // ==========================================================
   // timeout counter; in lin mode it runs only during a frame, outside lin mode it counts between pin edges
   logic hit;
   assign hit = lin_mode && frame_s &&
                (cnt_q == ocr_q.cv1 || (!mode_q && cnt_q == ocr_q.cv2));

   // outside lin mode the counter is cleared on each pin edge and counts between them, which is how cv2 picks up junk
   always_ff @(posedge CLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
         cnt_q <= 8'h00;
      else if (lin_mode ? !frame_s : pin_act)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_q + 8'h01;
   end

   // event pulse, sticky status and masked level interrupt
   always_ff @(posedge CLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         TIMEOUT <= 1'b0;
         irqs_q  <= 1'b0;
         IRQ     <= 1'b0;
      end
      else
      begin
         TIMEOUT <= hit;
         if (hit)
            irqs_q <= 1'b1;  // set beats clear
         else if (w_irqs && wr_q.data[IRQ_TO_BIT])
            irqs_q <= 1'b0;
         IRQ <= irqs_q && irqm_q;
      end
   end

   // ==========================================================
   // checks
   AST_MODE_RST: assert property (@(posedge CLK) $rose(rst_n_q) |-> !mode_q)
      else $error("mode bit not zero after reset");
   AST_CV2_HOLD_LIN: assert property (@(posedge CLK) disable iff (!rst_n_q)
      (lin_mode && !w_ocr) |=> $stable(ocr_q))
      else $error("compare values changed without a write in lin mode");
   AST_CV2_UART: assert property (@(posedge CLK) disable iff (!rst_n_q)
      (!w_ocr && ucr_q == 2'h2 && !mode_q && pin_act) |=> ocr_q.cv2 == $past(cnt_q))
      else $error("cv2 not altered by uart activity");
   AST_TO_PULSE: assert property (@(posedge CLK) disable iff (!rst_n_q)
      hit |=> (TIMEOUT && irqs_q))
      else $error("timeout not raised on compare hit");
   AST_STALE_CV2: assert property (@(posedge CLK) disable iff (!rst_n_q)
      (lin_mode && frame_s && !mode_q && cnt_q == ocr_q.cv2) |=> TIMEOUT)
      else $error("stale cv2 did not raise timeout");
   AST_IRQ_LVL: assert property (@(posedge CLK) disable iff (!rst_n_q)
      (irqs_q && irqm_q) |=> IRQ)
      else $error("irq missing");
endmodule : lin_timeout_compare_mode_switch
`default_nettype wire

// file: lin_to_pkg.sv
`default_nettype none
package lin_to_pkg;
   // register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] TCSR_OFS  = 8'h00;  // timeout control status reg
   localparam logic [7:0] OCR_OFS   = 8'h04;  // output compare reg
   localparam logic [7:0] UCR_OFS   = 8'h08;  // uart control reg
   localparam logic [7:0] CNT_OFS   = 8'h0C;  // live timeout counter
   localparam logic [7:0] IRQS_OFS  = 8'h10;  // sticky event status
   localparam logic [7:0] IRQM_OFS  = 8'h14;  // interrupt mask
   // field positions
   localparam int TCSR_MODE_BIT = 0;
   localparam int UCR_UART_BIT  = 0;
   localparam int UCR_EN_BIT    = 1;
   localparam int IRQ_TO_BIT    = 0;
   // values after reset, and axi response codes
   localparam logic        MODE_RST = 1'b0;
   localparam logic [15:0] OCR_RST  = 16'hFFFF;
   localparam logic [1:0]  UCR_RST  = 2'h0;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // axi write address/data, captured separately and held together until the write fires
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } wr_req_t;
   // compare pair
   typedef struct packed {
      logic [7:0] cv2;
      logic [7:0] cv1;
   } cmp_t;
endpackage : lin_to_pkg
`default_nettype wire

// file: lin_peer.sv
`default_nettype none
// =====================================
// line peer: uart pin traffic and lin frames
module lin_peer
(
   // clock
   input  wire logic clk,
   // line levels toward the block
   output var  logic rxd,
   output var  logic txd_mon,
   output var  logic frame
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle line rests high, no frame
   initial
   begin
      rxd = 1'b1;
      txd_mon = 1'b1;
      frame = 1'b0;
   end
   // n edges on both pins, even n leaves the line idle
   task automatic edges(input int n);
      repeat (n)
      begin
         repeat (4) @(posedge clk);
         rxd <= ~rxd;
         txd_mon <= ~txd_mon;
      end
   endtask : edges
   // frame of len cycles, opened only between frames
   task automatic run(input int len);
      @(posedge clk);
      frame <= 1'b1;
      repeat (len) @(posedge clk);
      frame <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : run
endmodule : lin_peer
`default_nettype wire

// file: lin_timeout_compare_mode_switch_tb.sv
`default_nettype none
// =====================================
// bench top
module lin_timeout_compare_mode_switch_tb;
   import lin_to_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, nrst = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, timeout, irq, rxd, txd_mon, frame;
   logic [1:0] bresp, rresp, r, wresp;
   logic [31:0] d;
   int num_errors = 0, samples_checked = 0, hits = 0;
   lin_timeout_compare_mode_switch i_lin_timeout_compare_mode_switch (
      .CLK(clk), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .RXD(rxd), .TXD_MON(txd_mon), .FRAME(frame), .TIMEOUT(timeout), .IRQ(irq));
   lin_peer i_lin_peer (.clk(clk), .rxd(rxd), .txd_mon(txd_mon), .frame(frame));
   // =====================================
   // clock and pulse counter
   initial
   begin
      forever #25 clk = ~clk;
   end
   // timeout is a one-cycle pulse, so count it at every edge
   always @(posedge clk)
   begin
      if (timeout === 1'b1) hits++;
   end
   // =====================================
   // helpers
   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic fail(input string m);
      num_errors++;
      $display("ERROR %0t %s", $time, m);
   endtask : fail
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail($sformatf("got %h expected %h", got, exp));
      end
   endtask : chk
   // address and data offered together, each dropped when taken
   task automatic wrs(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
      bit done;
      done = 0;
      @(posedge clk);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, v, s, 3'b111};
      for (int n = 0; n < 100 && !done; n++)
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid)
         begin
            wresp = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
      if (!done)
      begin
         fail("write hang");
         print_verdict();
      end
   endtask : wrs
   // full-word write, all byte lanes on
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      wrs(a, v, 4'hF);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      bit done;
      done = 0;
      @(posedge clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      for (int n = 0; n < 100 && !done; n++)
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid)
         begin
            {v, e} = {rdata, rresp};
            rready <= 1'b0;
            done = 1;
         end
      end
      if (!done)
      begin
         fail("read hang");
         print_verdict();
      end
   endtask : rd
   // =====================================
   // scenarios
   initial
   begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      rd(TCSR_OFS, d, r); chk(d, 32'h0);
      rd(OCR_OFS, d, r); chk(d, {16'h0, OCR_RST});
      rd(8'h20, d, r); chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      // unmapped write is refused with an error response
      wr(8'h20, 32'h1); chk({30'h0, wresp}, {30'h0, RESP_SLVERR});
      rd(TCSR_OFS, d, r); chk(d, 32'h0);
      // uart traffic with mode at zero spoils the second compare value
      wr(UCR_OFS, 32'h2);
      i_lin_peer.edges(6);
      rd(OCR_OFS, d, r); chk({d[7:0], 7'h0, d[15:8] !== 8'hFF}, 16'hFF01);
      // switch to lin now and the stale value fires in the first frame
      wr(IRQM_OFS, 32'h1);
      wr(UCR_OFS, 32'h3);
      hits = 0;
      i_lin_peer.run(300);
      chk({31'h0, hits > 0}, 32'h1);
      rd(IRQS_OFS, d, r); chk({d[0], irq}, 2'b11);
      wr(IRQS_OFS, 32'h1);
      rd(IRQS_OFS, d, r); chk({d[0], irq}, 2'b00);
      // safe switch: mode set before lin select
      wr(UCR_OFS, 32'h0);
      wr(OCR_OFS, 32'hFFFF);
      wr(TCSR_OFS, 32'h1);
      wr(UCR_OFS, 32'h2);
      i_lin_peer.edges(6);
      rd(OCR_OFS, d, r); chk(d, 32'hFFFF);
      wr(UCR_OFS, 32'h3);
      hits = 0;
      i_lin_peer.run(200);
      chk(hits, 0);
      // clearing mode keeps old compares, both then match in a frame
      wr(OCR_OFS, 32'h2010);
      wr(TCSR_OFS, 32'h0);
      rd(OCR_OFS, d, r); chk(d, 32'h2010);
      hits = 0;
      i_lin_peer.run(40);
      chk(hits, 2);
      // counter held at zero between lin frames
      rd(CNT_OFS, d, r); chk(d, 32'h0);
      // low byte lane only: cv1 changes, cv2 stays
      wrs(OCR_OFS, 32'h0000_5512, 4'h1);
      chk({30'h0, wresp}, {30'h0, RESP_OKAY});
      rd(OCR_OFS, d, r); chk(d, 32'h2012);
      wr(OCR_OFS, 32'hFFFF);
      hits = 0;
      i_lin_peer.run(200);
      chk(hits, 0);
      print_verdict();
   end
endmodule : lin_timeout_compare_mode_switch_tb
`default_nettype wire
